// ==== synth_regs_pkg.sv ====
`default_nettype none
package synth_regs_pkg;
	localparam int REG_AW = 7;
	localparam int REG_DW = 24;
	localparam logic [6:0] MODES_ADDR = 7'h17;
	localparam logic [6:0] BIAS_ADDR = 7'h18;
	localparam logic [6:0] CAL_ADDR = 7'h19;
	localparam logic [6:0] SEED_ADDR = 7'h1a;
	localparam logic [23:0] MODES_RESET = 24'h0001ab;
	localparam logic [23:0] BIAS_RESET = 24'h0054c1;
	localparam logic [23:0] CAL_RESET = 24'h000aaa;
	localparam logic [23:0] CAL_REQUIRED = 24'h000ab2;
	localparam logic [23:0] SEED_RESET = 24'hb29d0b;
	localparam int SEED_W = 24;
	localparam int MODE_MASTER = 0;
	localparam int MODE_VCO = 1;
	localparam int MODE_EXT_BUF = 2;
	localparam int MODE_PLL_BUF = 3;
	localparam int MODE_PRI_BUF = 4;
	localparam int MODE_SEC_BUF = 5;
	localparam int MODE_EXT_IN = 6;
	localparam int MODE_MUTE = 7;
	localparam int MODE_PRI_SE = 8;
	localparam int MODE_SEC_SE = 9;
	localparam int MODE_PUMP_SEL = 11;
	localparam int BIAS_LSB = 19;
	localparam int BIAS_W = 2;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [23:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic master_en;
		logic vco_en;
		logic ext_buf_en;
		logic pll_buf_en;
		logic pri_pos_en;
		logic pri_neg_en;
		logic sec_pos_en;
		logic sec_neg_en;
		logic ext_in_en;
		logic first_pump_en;
		logic second_pump_en;
		logic [1:0] ext_bias;
	} path_ctrl_s;

	typedef struct packed {
		logic [23:0] seed;
		logic load;
	} phase_cmd_s;
endpackage
`default_nettype wire

// ==== phase_seed_loader.sv ====
`default_nettype none
module phase_seed_loader #(
	parameter int SEED_W = 24
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [SEED_W-1:0] seed_in,
	input wire logic automatic_seed_in,
	input wire logic freq_change_in,
	input wire logic start_in,
	output logic [SEED_W-1:0] phase_out,
	output logic load_out
);
	typedef struct packed {
		logic [SEED_W-1:0] phase;
		logic load;
	} st_s;
	st_s q, d;

	always_comb
	begin
		d = q;
		d.load = 1'b0;
		// Phase word is seed/2^SEED_W of a full turn
		if (start_in || (!automatic_seed_in && freq_change_in)) // [R17] [R18] [R16]
		begin
			d.phase = seed_in;
			d.load = 1'b1;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
			q <= '0;
		else
			q <= d;
	end

	assign phase_out = q.phase;
	assign load_out = q.load;
endmodule
`default_nettype wire

// ==== synth_mode_bias_seed_regs.sv ====
// What this block does
// [R1] Modes bit 0 plus power pin gate VCO
// [R2] Modes bit 2 enables external VCO buffer
// [R3] Modes bit 3 enables PLL buffer
// [R4] Modes bit 4 enables primary output buffer
// [R5] Modes bit 5 enables secondary output buffer
// [R6] Modes bit 6 enables external VCO input
// [R7] Modes bit 7 mutes outputs until lock
// [R8] Modes bit 8 primary single-ended on negative pin
// [R9] Modes bit 9 secondary single-ended on negative pin
// [R10] Modes bit 11 routes pump to second output
// [R11] Modes register resets to 1ab
// [R12] Bias bits 20:19 set external buffer bias
// [R13] Bias register resets to 54c1
// [R14] Software programs calibration to ab2
// [R15] Seed register holds 24-bit reset b29d0b seed
// [R16] Phase equals two pi times seed/2^24
// [R17] Automatic seed: seed sets start phase
// [R18] Manual seed: seed reapplied each frequency change
// [R19] Software preserves reserved fields on writes
`default_nettype none
module synth_mode_bias_seed_regs (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [6:0] reg_addr_in,
	input wire logic [23:0] reg_wdata_in,
	input wire logic power_gate_in,
	input wire logic pll_lock_in,
	input wire logic automatic_seed_in,
	input wire logic freq_change_in,
	output logic [23:0] reg_rdata_out,
	output logic reg_rvalid_out,
	output logic master_en_out,
	output logic vco_en_out,
	output logic ext_buf_en_out,
	output logic pll_buf_en_out,
	output logic primary_pos_pin_en_out,
	output logic primary_neg_pin_en_out,
	output logic secondary_pos_pin_en_out,
	output logic secondary_neg_pin_en_out,
	output logic ext_in_en_out,
	output logic first_pump_output_en_out,
	output logic second_pump_output_en_out,
	output logic [1:0] ext_bias_out,
	output logic [23:0] calibration_out,
	output logic cal_ok_out,
	output logic [23:0] phase_out,
	output logic phase_load_out
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [23:0] modes;
		logic [23:0] bias;
		logic [23:0] cal;
		logic [23:0] seed;
		logic [23:0] rdata;
		logic rvalid;
		synth_regs_pkg::path_ctrl_s ctrl;
		logic cal_ok;
		logic start;
		logic [1:0] pg_sync;
		logic [1:0] lock_sync;
		logic [1:0] fc_sync;
		logic [1:0] as_sync;
		logic fc_prev;
	} state_s;

	state_s q, d;
	synth_regs_pkg::reg_req_s req;
	logic [23:0] seed_phase;
	logic seed_load;
	logic pg_en;
	logic locked;
	logic fc_edge;

	assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};

	typedef enum logic [2:0] {
		SEL_NONE = 3'h0,
		SEL_MODES = 3'h1,
		SEL_BIAS = 3'h2,
		SEL_CAL = 3'h3,
		SEL_SEED = 3'h4
	} reg_sel_e;

	////////////////////////////////////////////////////////////////////////
	// Address decode shared by the write side and the read side
	function automatic reg_sel_e reg_select(input logic [6:0] a);
		case (a)
			synth_regs_pkg::MODES_ADDR: reg_select = SEL_MODES;
			synth_regs_pkg::BIAS_ADDR: reg_select = SEL_BIAS;
			synth_regs_pkg::CAL_ADDR: reg_select = SEL_CAL;
			synth_regs_pkg::SEED_ADDR: reg_select = SEL_SEED;
			default: reg_select = SEL_NONE;
		endcase
	endfunction

	// Unmapped addresses read as zero
	function automatic logic [23:0] read_mux(input logic [6:0] a, input state_s s);
		case (reg_select(a))
			SEL_MODES:
			begin
				read_mux = s.modes;
			end
			SEL_BIAS:
			begin
				read_mux = s.bias;
			end
			SEL_CAL:
			begin
				read_mux = s.cal;
			end
			SEL_SEED:
			begin
				read_mux = s.seed;
			end
			default:
			begin
				read_mux = '0;
			end
		endcase
	endfunction

	// Start flag is set so the loader takes the reset seed right after release
	function automatic state_s reset_state();
		state_s s;
		s = '0;
		s.modes = synth_regs_pkg::MODES_RESET; // [R11]
		s.bias = synth_regs_pkg::BIAS_RESET; // [R13]
		s.cal = synth_regs_pkg::CAL_RESET;
		s.seed = synth_regs_pkg::SEED_RESET; // [R15]
		s.start = 1'b1;
		return s;
	endfunction

	// One step of a two-stage pin synchroniser
	function automatic logic [1:0] sync_step(input logic [1:0] s, input logic pin);
		return {s[0], pin};
	endfunction

	// Full-word write; unmapped addresses change nothing.
	// Reserved bits are stored as written, so software must keep them.
	function automatic state_s write_word(input state_s s, input synth_regs_pkg::reg_req_s r);
		state_s w;
		w = s;
		case (reg_select(r.addr))
			SEL_MODES:
			begin
				w.modes = r.wdata;
			end
			SEL_BIAS:
			begin
				w.bias = r.wdata;
			end
			SEL_CAL:
			begin
				// Stored as written; a wrong trim is only flagged
				w.cal = r.wdata;
			end
			SEL_SEED:
			begin
				w.seed = r.wdata; // [R15]
				// A new seed is always applied once as start phase
				w.start = 1'b1; // [R17]
			end
			default:
			begin
				w.start = 1'b0;
			end
		endcase
		return w;
	endfunction

	// Negative pin follows the buffer; positive pin drops out when single-ended
	function automatic logic [1:0] pin_pair(
		input logic buf_en,
		input logic single_ended,
		input logic muted
	);
		logic neg;
		logic pos;
		neg = buf_en & ~muted;
		pos = neg & ~single_ended;
		return {pos, neg};
	endfunction

	// Mute gates only the output pins; the rest of the path stays up
	function automatic synth_regs_pkg::path_ctrl_s decode_paths(
		input logic [23:0] modes,
		input logic [23:0] bias,
		input logic pg,
		input logic lock
	);
		synth_regs_pkg::path_ctrl_s c;
		logic muted;
		logic [1:0] pri;
		logic [1:0] sec;
		c = '0;
		muted = modes[synth_regs_pkg::MODE_MUTE] & ~lock; // [R7]
		pri = pin_pair(modes[synth_regs_pkg::MODE_PRI_BUF], // [R4]
			modes[synth_regs_pkg::MODE_PRI_SE], muted); // [R8]
		sec = pin_pair(modes[synth_regs_pkg::MODE_SEC_BUF], // [R5]
			modes[synth_regs_pkg::MODE_SEC_SE], muted); // [R9]
		c.master_en = modes[synth_regs_pkg::MODE_MASTER] & pg; // [R1]
		c.vco_en = c.master_en & modes[synth_regs_pkg::MODE_VCO]; // [R1]
		c.ext_buf_en = modes[synth_regs_pkg::MODE_EXT_BUF]; // [R2]
		c.pll_buf_en = modes[synth_regs_pkg::MODE_PLL_BUF]; // [R3]
		c.ext_in_en = modes[synth_regs_pkg::MODE_EXT_IN]; // [R6]
		c.pri_pos_en = pri[1];
		c.pri_neg_en = pri[0];
		c.sec_pos_en = sec[1];
		c.sec_neg_en = sec[0];
		c.first_pump_en = ~modes[synth_regs_pkg::MODE_PUMP_SEL]; // [R10]
		c.second_pump_en = modes[synth_regs_pkg::MODE_PUMP_SEL]; // [R10]
		c.ext_bias = bias[synth_regs_pkg::BIAS_LSB +: synth_regs_pkg::BIAS_W]; // [R12]
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d = q;
		// Pins cross in from outside; only the second stage is read
		d.pg_sync = sync_step(q.pg_sync, power_gate_in);
		d.lock_sync = sync_step(q.lock_sync, pll_lock_in);
		d.fc_sync = sync_step(q.fc_sync, freq_change_in);
		d.as_sync = sync_step(q.as_sync, automatic_seed_in);
		d.fc_prev = q.fc_sync[1];
		pg_en = q.pg_sync[1];
		locked = q.lock_sync[1];
		d.start = 1'b0;

		// A write and a read in one cycle return the old value
		if (req.wr)
		begin
			d = write_word(d, req);
		end

		d.rvalid = req.rd;
		d.rdata = req.rd ? read_mux(req.addr, q) : q.rdata;

		// Enables follow the stored words one cycle later
		d.ctrl = decode_paths(q.modes, q.bias, pg_en, locked); // [R1] [R7]
		// Flag only; the register does not force the value [R14]
		d.cal_ok = (q.cal == synth_regs_pkg::CAL_REQUIRED);
	end

	assign fc_edge = q.fc_sync[1] & ~q.fc_prev;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
			q <= reset_state(); // [R11] [R13] [R15]
		else
			q <= d;
	end

	phase_seed_loader #(
		.SEED_W(synth_regs_pkg::SEED_W)
	) u_loader (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.seed_in(q.seed),
		.automatic_seed_in(q.as_sync[1]),
		.freq_change_in(fc_edge), // [R18]
		.start_in(q.start), // [R17]
		.phase_out(seed_phase),
		.load_out(seed_load)
	);

	////////////////////////////////////////////////////////////////////////
	assign reg_rdata_out = q.rdata;
	assign reg_rvalid_out = q.rvalid;
	assign master_en_out = q.ctrl.master_en;
	assign vco_en_out = q.ctrl.vco_en;
	assign ext_buf_en_out = q.ctrl.ext_buf_en;
	assign pll_buf_en_out = q.ctrl.pll_buf_en;
	assign primary_pos_pin_en_out = q.ctrl.pri_pos_en;
	assign primary_neg_pin_en_out = q.ctrl.pri_neg_en;
	assign secondary_pos_pin_en_out = q.ctrl.sec_pos_en;
	assign secondary_neg_pin_en_out = q.ctrl.sec_neg_en;
	assign ext_in_en_out = q.ctrl.ext_in_en;
	assign first_pump_output_en_out = q.ctrl.first_pump_en;
	assign second_pump_output_en_out = q.ctrl.second_pump_en;
	assign ext_bias_out = q.ctrl.ext_bias;
	assign calibration_out = q.cal;
	assign cal_ok_out = q.cal_ok;
	assign phase_out = seed_phase;
	assign phase_load_out = seed_load;
endmodule
`default_nettype wire

// ==== synth_regs_monitor.sv ====
`default_nettype none
module synth_regs_monitor (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic reg_wr_in,
	input wire logic [6:0] reg_addr_in,
	input wire logic [23:0] reg_wdata_in,
	input wire logic master_en_out,
	input wire logic vco_en_out,
	input wire logic ext_buf_en_out,
	input wire logic pll_buf_en_out,
	input wire logic primary_pos_pin_en_out,
	input wire logic primary_neg_pin_en_out,
	input wire logic secondary_pos_pin_en_out,
	input wire logic secondary_neg_pin_en_out,
	input wire logic ext_in_en_out,
	input wire logic second_pump_output_en_out,
	input wire logic [1:0] ext_bias_out,
	input wire logic cal_ok_out,
	input wire logic [23:0] phase_out,
	input wire logic phase_load_out
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic wm = reg_wr_in && reg_addr_in == 7'h17;
	wire logic wb = reg_wr_in && reg_addr_in == 7'h18;
	wire logic wc = reg_wr_in && reg_addr_in == 7'h19;
	wire logic ws = reg_wr_in && reg_addr_in == 7'h1a;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	//////////////////////////////////////////////////////////////////////
	vco_gate_a: assert property (vco_en_out |-> master_en_out)
		else $error("vco enabled without master");
	ext_buf_a: assert property (wm |-> ##2 ext_buf_en_out == $past(reg_wdata_in[2], 2))
		else $error("external buffer enable wrong");
	pll_buf_a: assert property (wm |-> ##2 pll_buf_en_out == $past(reg_wdata_in[3], 2))
		else $error("pll buffer enable wrong");
	single_end_a: assert property (primary_pos_pin_en_out |-> primary_neg_pin_en_out)
		else $error("positive pin without negative pin");
	sec_single_a: assert property (secondary_pos_pin_en_out |-> secondary_neg_pin_en_out)
		else $error("secondary positive pin without negative pin");
	ext_in_a: assert property (wm |-> ##2 ext_in_en_out == $past(reg_wdata_in[6], 2))
		else $error("external input enable wrong");
	pump_sel_a: assert property (wm |-> ##2
		second_pump_output_en_out == $past(reg_wdata_in[11], 2))
		else $error("pump routing wrong");
	bias_field_a: assert property (wb |-> ##2 ext_bias_out == $past(reg_wdata_in[20:19], 2))
		else $error("bias field wrong");
	cal_flag_a: assert property (wc |-> ##2
		cal_ok_out == ($past(reg_wdata_in, 2) == 24'h000ab2))
		else $error("calibration flag wrong");
	seed_load_a: assert property (ws |-> ##2
		phase_load_out && phase_out == $past(reg_wdata_in, 2))
		else $error("seed not loaded");
endmodule
bind synth_mode_bias_seed_regs synth_regs_monitor mon (.clk_in, .nrst_in, .reg_wr_in, .reg_addr_in,
	.reg_wdata_in, .master_en_out, .vco_en_out, .ext_buf_en_out, .pll_buf_en_out,
	.primary_pos_pin_en_out, .primary_neg_pin_en_out, .secondary_pos_pin_en_out,
	.secondary_neg_pin_en_out, .ext_in_en_out, .second_pump_output_en_out, .ext_bias_out,
	.cal_ok_out, .phase_out, .phase_load_out);
`default_nettype wire

// ==== tb.sv ====
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = '0, nrst_in = '0, reg_wr_in = '0, reg_rd_in = '0, power_gate_in = 1'h1;
	logic pll_lock_in = '0, automatic_seed_in = '0, freq_change_in = '0, f;
	logic [6:0] reg_addr_in = '0;
	logic [23:0] reg_wdata_in = '0, reg_rdata_out, calibration_out, phase_out, m, v;
	logic reg_rvalid_out, master_en_out, vco_en_out, ext_buf_en_out, pll_buf_en_out;
	logic primary_pos_pin_en_out, primary_neg_pin_en_out, secondary_pos_pin_en_out;
	logic secondary_neg_pin_en_out, ext_in_en_out, first_pump_output_en_out;
	logic second_pump_output_en_out, cal_ok_out, phase_load_out, g, l;
	logic [1:0] ext_bias_out;
	logic [23:0] expq [$];
	int failures = 0, comparisons = 0;
	wire logic [10:0] obs = {master_en_out, vco_en_out, ext_buf_en_out, pll_buf_en_out,
		primary_pos_pin_en_out, primary_neg_pin_en_out, secondary_pos_pin_en_out,
		secondary_neg_pin_en_out, ext_in_en_out, first_pump_output_en_out, second_pump_output_en_out};
	synth_mode_bias_seed_regs DUT (.clk_in, .nrst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
		.reg_wdata_in, .power_gate_in, .pll_lock_in, .automatic_seed_in, .freq_change_in,
		.reg_rdata_out, .reg_rvalid_out, .master_en_out, .vco_en_out, .ext_buf_en_out,
		.pll_buf_en_out, .primary_pos_pin_en_out, .primary_neg_pin_en_out,
		.secondary_pos_pin_en_out, .secondary_neg_pin_en_out, .ext_in_en_out,
		.first_pump_output_en_out, .second_pump_output_en_out, .ext_bias_out, .calibration_out,
		.cal_ok_out, .phase_out, .phase_load_out);
	initial forever #25 clk_in = !clk_in;
	//////////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [23:0] e, logic [23:0] s);
		comparisons++;
		if (s !== e)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic wrt(logic [6:0] a, logic [23:0] d);
		@(posedge clk_in);
		reg_wr_in <= 1'h1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in <= 1'h0;
	endtask
	task automatic rdx(logic [6:0] a, logic [23:0] e);
		@(posedge clk_in);
		reg_rd_in <= 1'h1;
		reg_addr_in <= a;
		expq.push_back(e);
		@(posedge clk_in);
		reg_rd_in <= 1'h0;
	endtask
	// Mute only drops pin enables while lock is absent
	function automatic logic [10:0] expm(logic [23:0] m, logic g, logic l);
		logic u;
		u = m[7] & !l;
		return {m[0] & g, m[0] & g & m[1], m[2], m[3], m[4] & !u & !m[8], m[4] & !u,
			m[5] & !u & !m[9], m[5] & !u, m[6], !m[11], m[11]};
	endfunction
	// Reload window covers the pin synchronisers plus margin
	task automatic ld(logic a, logic e);
		automatic_seed_in <= a;
		cyc(4);
		freq_change_in <= 1'h1;
		f = 1'h0;
		repeat (12)
		begin
			@(posedge clk_in);
			if (phase_load_out === 1'h1)
				f = 1'h1;
		end
		freq_change_in <= 1'h0;
		chk("reload", 24'(e), 24'(f));
	endtask
	task automatic results;
		failures += expq.size();
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////
	always @(posedge clk_in)
		if (reg_rvalid_out === 1'h1)
			chk("rdata", expq.pop_front(), reg_rdata_out);
	initial
	begin
		cyc(3000);
		failures++;
		results();
	end
	initial
	begin
		v = 24'($urandom(32'h25e7b1dd));
		cyc(2);
		nrst_in <= 1'h1;
		cyc(5);
		chk("modes", 24'(expm(24'h0001ab, 1'h1, 1'h0)), 24'(obs));
		chk("phase", 24'hb29d0b, phase_out);
		chk("calok", 24'h0, 24'(cal_ok_out));
		rdx(7'h17, 24'h0001ab);
		rdx(7'h18, 24'h0054c1);
		rdx(7'h19, 24'h000aaa);
		rdx(7'h1a, 24'hb29d0b);
		rdx(7'h00, 24'h0);
		repeat (12)
		begin
			// Reserved modes bits stay at their reset value of zero
			m = 24'($urandom) & 24'h000bff;
			g = 1'($urandom);
			l = 1'($urandom);
			power_gate_in <= g;
			pll_lock_in <= l;
			wrt(7'h17, m);
			cyc(5);
			chk("modes", 24'(expm(m, g, l)), 24'(obs));
			pll_lock_in <= 1'h1;
			cyc(5);
			chk("unmute", 24'(expm(m, g, 1'h1)), 24'(obs));
			rdx(7'h17, m);
		end
		// Only the bias field is random; reserved bits keep their defaults
		m = (24'($urandom) & 24'h180000) | 24'h0054c1;
		wrt(7'h18, m);
		cyc(3);
		chk("bias", 24'(m[20:19]), 24'(ext_bias_out));
		rdx(7'h18, m);
		wrt(7'h19, 24'h000ab2);
		cyc(3);
		chk("cal", 24'h000ab2, calibration_out);
		chk("calok", 24'h1, 24'(cal_ok_out));
		wrt(7'h1a, v);
		cyc(2);
		chk("seed", v, phase_out);
		ld(1'h0, 1'h1);
		chk("seed", v, phase_out);
		ld(1'h1, 1'h0);
		cyc(4);
		results();
	end
endmodule
`default_nettype wire
